//--- logic/mtm_pkg.sv
// Shared constants and types for the modulo timer.
package mtm_pkg;
  // Register word offsets on the plain register port.
  localparam logic [1:0] OFS_SC = 2'h0;
  localparam logic [1:0] OFS_CC = 2'h1;
  localparam logic [1:0] OFS_CNT = 2'h2;
  localparam logic [1:0] OFS_MOD = 2'h3;
  // Status and control bit positions.
  localparam int BIT_OVF = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_TRST = 5;
  localparam int BIT_STOP = 4;
  // Clock configuration field positions.
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 4;
  localparam int PS_HI = 3;
  localparam int PS_LO = 0;
  // Prescaler code that already divides by the largest ratio.
  localparam logic [3:0] PS_MAX = 4'h8;
  // Reset values and common byte constants.
  localparam logic RST_STOP = 1'b1;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [3:0] RST_PS = 4'h0;
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [7:0] RST_MOD = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] FULL8 = 8'hFF;
  // Prescaler input sources, in clock source select order.
  typedef enum logic [1:0] {
    SRC_BUS,
    SRC_FIX,
    SRC_PIN_FALL,
    SRC_PIN_RISE
  } mtm_src_t;
endpackage

//--- logic/mtm_presc_if.sv
// Carrier between the timer core and its prescaler.
`timescale 1ns/100ps
interface mtm_presc_if;
  logic [1:0] src_sel; // Chosen prescaler source.
  logic [3:0] ps_sel; // Division ratio code.
  logic run; // High while counting is allowed.
  logic clr; // Clears the prescaler divider.
  logic tick; // One-cycle counter advance.
  modport ctl(output src_sel, output ps_sel, output run, output clr, input tick);
  modport pre(input src_sel, input ps_sel, input run, input clr, output tick);
endinterface

//--- logic/mtm_prescaler.sv
// Source selection, pin synchronisers and divide-by-2^n prescaler.
`timescale 1ns/100ps
module mtm_prescaler #(
  parameter int DIV_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic ext_timer_clock_pin_i,
  input wire logic fixed_freq_clock_i,
  mtm_presc_if.pre pif
);
  // Lane 0 is the timer pin, lane 1 the fixed-frequency clock.
  logic [1:0] s1_q, s2_q, s3_q; // Three-stage synchronisers.
  logic [1:0] lvl_q; // Filtered level per lane.
  logic [1:0] lvl_d;
  logic [1:0] rise, fall;
  logic src_edge;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;

  // Mask of low divider bits that must all be ones for a tick.
  function automatic logic [DIV_W-1:0] ps_mask(input logic [3:0] ps);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++) begin
      if (4'(i) < ps || ps >= mtm_pkg::PS_MAX) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // A level change counts only once stages two and three agree.
  assign lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;
  assign mask = ps_mask(pif.ps_sel);

  // The bus clock counts every cycle; the others count filtered edges.
  assign src_edge = (pif.src_sel == mtm_pkg::SRC_BUS) ? 1'b1 :
                    (pif.src_sel == mtm_pkg::SRC_FIX) ? rise[1] :
                    (pif.src_sel == mtm_pkg::SRC_PIN_FALL) ? fall[0] :
                    rise[0];
  assign pif.tick = pif.run & src_edge & ((div_q & mask) == mask);

  // Synchronisers run whenever ce_i is high, whatever the source or run state, so the pin may also feed other timers.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      lvl_q <= 2'h0;
    end else if (ce_i) begin
      s1_q <= {fixed_freq_clock_i, ext_timer_clock_pin_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Divider advances on source edges only while running.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
    end else if (ce_i) begin
      if (pif.clr) begin
        div_q <= '0;
      end else if (pif.run && src_edge) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // A halted run must neither tick nor move the divider, or a resumed count would slip.
  a_tick_needs_run: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && !pif.run && !pif.clr |-> !pif.tick ##1 $stable(div_q))
    else $error("tick or divider step while not running");
endmodule

//--- logic/mtm_timer.sv
// Top of the 8-bit modulo timer with its register port.
// Functional notes
// - 8-bit up-counter, free-running or modulo.
// - Overflow interrupt can be enabled by software.
// - Four selectable prescaler input sources.
// - Prescale ratios 1 through 256 in powers.
// - Both pin codes select the timer pin.
// - Timer pin stays shareable with other timers.
// - Keeps counting in wait; interrupt wakes.
// - No counting in any stop mode.
// - Deep stop wake restores reset values.
// - Light stop interrupt exit keeps state.
// - Debug mode suspends all counting.
// - After debug, resume unless reset happened.
// - Timer pin synchronised to bus clock.
// - Four 8-bit software registers.
// - Counter reset and counter stop bits.
// - Flag sets on wrap; read-then-zero clears.
// - Reset bit zeroes counter, clears flag.
// - Stop bit freezes counter; set at reset.
// - Source field resets zero, keeps count.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module mtm_timer #(
  parameter int AW = 2,
  parameter int DW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  input wire logic ext_timer_clock_pin_i,
  input wire logic fixed_freq_clock_i,
  input wire logic stop_mode_i,
  input wire logic stop_wake_reset_i,
  input wire logic bdm_active_i,
  output logic irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Control and status state.
  logic flag_q, flag_d; // Overflow flag.
  logic ie_q, ie_d; // Overflow interrupt enable.
  logic stop_q, stop_d; // Counter stop bit.
  logic [1:0] src_q, src_d; // Clock source select.
  logic [3:0] ps_q, ps_d; // Prescale code.
  logic [DW-1:0] cnt_q, cnt_d; // The counter itself.
  logic [DW-1:0] mod_q, mod_d; // Modulo limit.
  logic armed_q, armed_d; // Status read while flag set.
  logic [DW-1:0] rdata_q, rdata_d;
  logic irq_q;

  // Named decode wires.
  logic sel_sc, sel_cc, sel_cnt, sel_mod;
  logic wr_sc, wr_cc, wr_mod, rd_sc;
  logic trst; // Counter reset request.
  logic soft_rst; // Return to reset values after deep stop.
  logic cnt_clr; // Any reset source that zeroes the counter.
  logic run; // Counting allowed this cycle.
  logic [DW-1:0] limit; // Value at which the counter wraps.
  logic wrap; // Counter wraps this cycle.
  logic flag_clr; // Software clear of the flag.
  logic [DW-1:0] sc_val, cc_val, rd_val;

  mtm_presc_if pif();

  // Assemble the status and control read value.
  function automatic logic [DW-1:0] pack_sc(input logic f, input logic e,
                                            input logic s);
    logic [DW-1:0] v;
    v = '0;
    v[mtm_pkg::BIT_OVF] = f;
    v[mtm_pkg::BIT_IE] = e;
    v[mtm_pkg::BIT_STOP] = s;
    return v;
  endfunction

  // Assemble the clock configuration read value.
  function automatic logic [DW-1:0] pack_cc(input logic [1:0] s,
                                            input logic [3:0] p);
    logic [DW-1:0] v;
    v = '0;
    v[mtm_pkg::SRC_HI:mtm_pkg::SRC_LO] = s;
    v[mtm_pkg::PS_HI:mtm_pkg::PS_LO] = p;
    return v;
  endfunction

  // Address decode; every offset of the two-bit space is mapped.
  assign sel_sc = (addr_i == mtm_pkg::OFS_SC);
  assign sel_cc = (addr_i == mtm_pkg::OFS_CC);
  assign sel_cnt = (addr_i == mtm_pkg::OFS_CNT);
  assign sel_mod = (addr_i == mtm_pkg::OFS_MOD);
  assign wr_sc = wr_i & sel_sc;
  assign wr_cc = wr_i & sel_cc;
  assign wr_mod = wr_i & sel_mod;
  assign rd_sc = rd_i & sel_sc;

  // Writing one to the reset bit is a pulse; the bit never stores.
  assign trst = wr_sc & wdata_i[mtm_pkg::BIT_TRST];
  assign soft_rst = stop_wake_reset_i;
  assign cnt_clr = soft_rst | trst | wr_mod;

  // Stop modes and debug freeze the count; wait mode does not.
  assign run = ~stop_q & ~stop_mode_i & ~bdm_active_i;

  // A zero modulo means the full 8-bit range.
  assign limit = (mod_q == mtm_pkg::ZERO8) ? mtm_pkg::FULL8 : mod_q;
  assign wrap = pif.tick & (cnt_q == limit);

  // Clear needs a prior status read seeing the flag, then a zero write.
  assign flag_clr = wr_sc & armed_q & ~wdata_i[mtm_pkg::BIT_OVF];

  // Read data selection.
  assign sc_val = pack_sc(flag_q, ie_q, stop_q);
  assign cc_val = pack_cc(src_q, ps_q);
  assign rd_val = sel_sc ? sc_val :
                  sel_cc ? cc_val :
                  sel_cnt ? cnt_q :
                  mod_q;

  // Prescaler hookup.
  assign pif.src_sel = src_q;
  assign pif.ps_sel = ps_q;
  assign pif.run = run;
  assign pif.clr = cnt_clr;

  mtm_prescaler #(
    .DIV_W(DW)
  ) u_presc (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .ext_timer_clock_pin_i(ext_timer_clock_pin_i),
    .fixed_freq_clock_i(fixed_freq_clock_i),
    .pif(pif.pre)
  );

  // Next counter value; any reset source beats a tick.
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_clr) begin
      cnt_d = mtm_pkg::RST_CNT;
    end else if (wrap) begin
      cnt_d = mtm_pkg::ZERO8;
    end else if (pif.tick) begin
      cnt_d = cnt_q + mtm_pkg::ONE8;
    end
  end

  // Next flag value. A wrap in the clearing cycle keeps the flag set,
  // so no overflow is lost; only the deep-stop reset overrides it.
  always_comb begin
    flag_d = flag_q;
    if (soft_rst) begin
      flag_d = 1'b0;
    end else if (wrap) begin
      flag_d = 1'b1;
    end else if (trst || wr_mod || flag_clr) begin
      flag_d = 1'b0;
    end
  end

  // Arming tracks a status read that saw the flag set.
  always_comb begin
    armed_d = armed_q;
    if (soft_rst || wr_sc) begin
      armed_d = 1'b0;
    end else if (rd_sc && flag_q) begin
      armed_d = 1'b1;
    end
  end

  // Control fields; writes to the count register are ignored.
  always_comb begin
    ie_d = ie_q;
    stop_d = stop_q;
    src_d = src_q;
    ps_d = ps_q;
    mod_d = mod_q;
    if (soft_rst) begin
      ie_d = 1'b0;
      stop_d = mtm_pkg::RST_STOP;
      src_d = mtm_pkg::RST_SRC;
      ps_d = mtm_pkg::RST_PS;
      mod_d = mtm_pkg::RST_MOD;
    end else begin
      if (wr_sc) begin
        ie_d = wdata_i[mtm_pkg::BIT_IE];
        stop_d = wdata_i[mtm_pkg::BIT_STOP];
      end
      if (wr_cc) begin
        src_d = wdata_i[mtm_pkg::SRC_HI:mtm_pkg::SRC_LO];
        ps_d = wdata_i[mtm_pkg::PS_HI:mtm_pkg::PS_LO];
      end
      if (wr_mod) begin
        mod_d = wdata_i;
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  assign rdata_d = rd_i ? rd_val : '0;

  // State registers; a low clock enable freezes everything.
  // Light-stop interrupt exit keeps all of this untouched.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      stop_q <= mtm_pkg::RST_STOP;
      src_q <= mtm_pkg::RST_SRC;
      ps_q <= mtm_pkg::RST_PS;
      cnt_q <= mtm_pkg::RST_CNT;
      mod_q <= mtm_pkg::RST_MOD;
      armed_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= flag_d;
      ie_q <= ie_d;
      stop_q <= stop_d;
      src_q <= src_d;
      ps_q <= ps_d;
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      armed_q <= armed_d;
    end
  end

  // Output registers, one flop straight to each pin.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
      irq_q <= flag_q & ie_q;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o = irq_q;

  // Counter reset write zeroes the count on the next edge.
  a_trst_zeroes_cnt: assert property (
    ce_i && trst |=> cnt_q == mtm_pkg::ZERO8)
    else $error("counter not zeroed by reset bit");

  // Modulo write loads the limit and zeroes the count.
  a_mod_write_resets: assert property (
    ce_i && wr_mod && !soft_rst |=> cnt_q == mtm_pkg::ZERO8 && mod_q == $past(wdata_i))
    else $error("modulo write did not reset counter");

  // Frozen counter holds its value while no reset source acts.
  a_frozen_holds: assert property (
    ce_i && !run && !cnt_clr |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  // A wrap returns to zero and sets the flag together.
  a_wrap_sets_flag: assert property (
    ce_i && wrap && !soft_rst |=> flag_q && cnt_q == mtm_pkg::ZERO8)
    else $error("wrap did not set flag");

  // Each tick below the limit adds exactly one.
  a_tick_steps_one: assert property (
    ce_i && pif.tick && !wrap && !cnt_clr |=> cnt_q == DW'($past(cnt_q) + mtm_pkg::ONE8))
    else $error("counter step wrong");

  // Interrupt output follows flag and enable one cycle later.
  a_irq_follows: assert property (
    ce_i |=> irq_o == $past(flag_q && ie_q))
    else $error("interrupt output mismatch");

  // Read then zero write clears the flag unless a wrap coincides.
  a_flag_clear_seq: assert property (
    ce_i && rd_sc && flag_q ##1 ce_i && wr_sc && !wdata_i[mtm_pkg::BIT_OVF] && !wrap
    |=> !flag_q)
    else $error("flag not cleared by read-write sequence");

  // Read data is zero outside the cycle after a read strobe.
  a_rdata_idle_zero: assert property (
    ce_i && !rd_i |=> rdata_o == mtm_pkg::ZERO8)
    else $error("read data outside its cycle");

  // Deep-stop wake restores the reset values.
  a_wake_resets: assert property (
    ce_i && soft_rst |=> stop_q && !flag_q && !ie_q && cnt_q == mtm_pkg::ZERO8)
    else $error("wake did not restore reset state");

  // Changing the source alone leaves the count in place.
  a_src_keeps_cnt: assert property (
    ce_i && wr_cc && !cnt_clr && !pif.tick |=> $stable(cnt_q))
    else $error("source change disturbed counter");
endmodule

//--- test/mtm_pin_src.sv
// Behavioural model of an external clock source feeding a timer clock input.
`timescale 1ns/100ps
module mtm_pin_src (
  input wire logic mclk_i,
  output logic pin_o
);
  // The line rests low between bursts, since this source is not free running.
  initial begin
    pin_o = 1'b0;
  end

  // Sends n pulses, each high and low for half bus cycles; half of two or more
  // keeps the rate at a quarter of the bus clock or below.
  task automatic burst(input int n, input int half);
    repeat (n) begin
      @(posedge mclk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge mclk_i);
      pin_o <= 1'b0;
      repeat (half - 1) @(posedge mclk_i);
    end
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the modulo timer, register port and clock sources.
`timescale 1ns/100ps
module testbench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic pin;
  logic fix;
  logic stop_mode_i = 1'b0;
  logic wake_i = 1'b0;
  logic bdm_active_i = 1'b0;
  logic ce_i = 1'b1; // Clock enable, dropped in one scenario to freeze the block.
  logic irq_o;
  logic rd_seen = 1'b0; // A read was taken at the last rising edge.
  logic [7:0] exp_q[$]; // Expected read data, oldest first.
  logic [31:0] seed = 32'hDC48;
  int bad_count = 0;
  int n_checks = 0;
  int g;

  mtm_timer uut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_timer_clock_pin_i(pin),
    .fixed_freq_clock_i(fix), .stop_mode_i(stop_mode_i), .stop_wake_reset_i(wake_i),
    .bdm_active_i(bdm_active_i), .irq_o(irq_o)
  );
  // The same source model serves the timer pin and the fixed-frequency input.
  mtm_pin_src pin_src (.mclk_i(mclk_i), .pin_o(pin));
  mtm_pin_src fix_src (.mclk_i(mclk_i), .pin_o(fix));

  // Bus clock at 40 MHz.
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Shift register for stimulus values, so every run sees the same sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One-cycle write strobe; returns at the edge that takes it.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // One-cycle read strobe; the answer is checked by the monitor below.
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(exp);
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask

  // Read data stand for one cycle only, so they are sampled mid-cycle.
  always @(posedge mclk_i) begin
    rd_seen <= rd_i;
  end
  always @(negedge mclk_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk8("rdata", exp_q.pop_front(), rdata_o);
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under ten thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    give_verdict();
  end

  // Main sequence; a run gap of k idle edges between start and stop writes gives k+2 ticks.
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(mtm_pkg::OFS_SC, 8'h10);
    rd(mtm_pkg::OFS_CC, 8'h00);
    rd(mtm_pkg::OFS_CNT, 8'h00);
    rd(mtm_pkg::OFS_MOD, 8'h00);
    // Random modulo values read back; counter writes are ignored.
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(mtm_pkg::OFS_MOD, seed[7:0]);
      wr(mtm_pkg::OFS_CNT, seed[15:8]);
      rd(mtm_pkg::OFS_MOD, seed[7:0]);
      rd(mtm_pkg::OFS_CNT, 8'h00);
    end
    // Modulo 4 with interrupt enabled: seven ticks wrap once and leave 2.
    wr(mtm_pkg::OFS_MOD, 8'h04);
    wr(mtm_pkg::OFS_SC, 8'h40);
    repeat (5) @(posedge mclk_i);
    wr(mtm_pkg::OFS_SC, 8'h50);
    @(negedge mclk_i);
    chk1("irq", 1'b1, irq_o);
    wr(mtm_pkg::OFS_SC, 8'h50);
    rd(mtm_pkg::OFS_CNT, 8'h02);
    // Status read straight followed by a zero write, with no idle cycle between.
    @(posedge mclk_i);
    addr_i <= mtm_pkg::OFS_SC;
    rd_i <= 1'b1;
    exp_q.push_back(8'hD0);
    @(posedge mclk_i);
    rd_i <= 1'b0;
    wdata_i <= 8'h10;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd(mtm_pkg::OFS_SC, 8'h10);
    @(negedge mclk_i);
    chk1("irq", 1'b0, irq_o);
    // Free running: 258 ticks wrap past FF once.
    wr(mtm_pkg::OFS_MOD, 8'h00);
    wr(mtm_pkg::OFS_SC, 8'h00);
    repeat (256) @(posedge mclk_i);
    wr(mtm_pkg::OFS_SC, 8'h10);
    rd(mtm_pkg::OFS_CNT, 8'h02);
    rd(mtm_pkg::OFS_SC, 8'h90);
    wr(mtm_pkg::OFS_SC, 8'h30);
    rd(mtm_pkg::OFS_SC, 8'h10);
    rd(mtm_pkg::OFS_CNT, 8'h00);
    // Prescale codes 0 through 9: three and a half periods give three ticks.
    for (int n = 0; n < 10; n++) begin
      wr(mtm_pkg::OFS_SC, 8'h30);
      wr(mtm_pkg::OFS_CC, {4'h0, n[3:0]});
      wr(mtm_pkg::OFS_SC, 8'h00);
      g = (n > 8) ? 256 : (1 << n);
      repeat (3 * g + g / 2 - 2) @(posedge mclk_i);
      wr(mtm_pkg::OFS_SC, 8'h10);
      rd(mtm_pkg::OFS_CNT, 8'h03);
    end
    // Fixed clock and both pin edges: five pulses give five ticks.
    for (int s = 1; s < 4; s++) begin
      wr(mtm_pkg::OFS_SC, 8'h30);
      wr(mtm_pkg::OFS_CC, {2'h0, s[1:0], 4'h0});
      wr(mtm_pkg::OFS_SC, 8'h00);
      if (s == 1) begin
        fix_src.burst(5, 2);
      end else begin
        pin_src.burst(5, 3);
      end
      repeat (8) @(posedge mclk_i);
      wr(mtm_pkg::OFS_SC, 8'h10);
      rd(mtm_pkg::OFS_CNT, 8'h05);
    end
    wr(mtm_pkg::OFS_CC, 8'h00);
    rd(mtm_pkg::OFS_CNT, 8'h05);
    // Stop mode, debug mode, then a low clock enable, each held for six edges
    // inside a fourteen-edge run, so eight ticks remain.
    for (int m = 0; m < 3; m++) begin
      wr(mtm_pkg::OFS_SC, 8'h30);
      wr(mtm_pkg::OFS_SC, 8'h00);
      repeat (3) @(posedge mclk_i);
      stop_mode_i <= (m == 0);
      bdm_active_i <= (m == 1);
      ce_i <= (m != 2);
      repeat (6) @(posedge mclk_i);
      stop_mode_i <= 1'b0;
      bdm_active_i <= 1'b0;
      ce_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      wr(mtm_pkg::OFS_SC, 8'h10);
      rd(mtm_pkg::OFS_CNT, 8'h08);
    end
    // Wake from deep stop returns every register to its reset value.
    wr(mtm_pkg::OFS_MOD, 8'h21);
    wr(mtm_pkg::OFS_CC, 8'h25);
    wr(mtm_pkg::OFS_SC, 8'h40);
    @(posedge mclk_i);
    stop_mode_i <= 1'b1;
    wake_i <= 1'b1;
    @(posedge mclk_i);
    stop_mode_i <= 1'b0;
    wake_i <= 1'b0;
    rd(mtm_pkg::OFS_SC, 8'h10);
    rd(mtm_pkg::OFS_CC, 8'h00);
    rd(mtm_pkg::OFS_CNT, 8'h00);
    rd(mtm_pkg::OFS_MOD, 8'h00);
    repeat (2) @(posedge mclk_i);
    give_verdict();
  end
endmodule
